// File: verilog/bit_function_consts.vh
// constants of the controller bit function unit
// assumes inclusion by bare name from the design file
`ifndef BIT_FUNCTION_CONSTS_VH
`define BIT_FUNCTION_CONSTS_VH

// ==========================================
// register word addresses
`define BFU_ADDR_FIRST      8'h00
`define BFU_ADDR_SECOND     8'h01
`define BFU_ADDR_RESULT     8'h02
`define BFU_ADDR_COMMAND    8'h03
`define BFU_ADDR_STATUS     8'h04
`define BFU_DREG_WINDOW_BIT 7
`define BFU_READ_IDLE       16'h0000

// ==========================================
// command codes written to the command register
`define BFU_CMD_TRANSFER    2'h0
`define BFU_CMD_DECENC      2'h1
`define BFU_CMD_COUNT       2'h2
`define BFU_CMD_INVERT      2'h3

// ==========================================
// operand encodings
`define BFU_K_THOUSAND      16'h03E8
`define BFU_K_HUNDRED       16'h0064
`define BFU_GROUPS_MIN      16'h0001
`define BFU_GROUPS_MAX      16'h0004
`define BFU_GROUP_CODE_MAX  16'h000F
`define BFU_DREG_LAST       16'h005F
`define BFU_SEL_DECODE      16'h0000
`define BFU_SEL_ENCODE      16'h0001
`define BFU_ONE_BIT         16'h0001

// ==========================================
// status fields and reset values
`define BFU_STAT_REFUSED    0
`define BFU_STAT_RAN        1
`define BFU_RESET_WORD      16'h0000

`endif

// File: verilog/controller_bit_function_unit.v
// controller bit function unit: transfer, decode/encode, bit count, invert
// assumes a plain register port master and output points from another domain
//
// Operation
// (RULE_01) transfer operand: thousands digit is group count 1..4, low two digits group code
// (RULE_02) program keeps the hundreds digit of the transfer operand at zero
// (RULE_03) group code indexes a sixteen point output group
// (RULE_04) transfer always starts at point zero of the chosen group
// (RULE_05) destination register comes from second operand minus one thousand
// (RULE_06) transfer refused when destination lies outside registers 0 to 95
// (RULE_07) four, eight or twelve bit transfers still fill one register
// (RULE_08) decode looks only at the low four input bits
// (RULE_09) decode writes a one-hot word with the bit at the input value
// (RULE_10) encode writes the set bit position, upper twelve result bits zero
// (RULE_11) program gives encode a word with exactly one bit set
// (RULE_12) second operand zero selects decode, one selects encode
// (RULE_13) bit count goes to the second operand, upper bits zero
// (RULE_14) invert replaces the named data register with its one's complement
// (RULE_15) program puts the register number to invert in the first operand
// (RULE_16) point k lands in bit k; bits beyond the group count cleared
// (RULE_17) each invocation strobe samples operands and runs the function once
`timescale 1ns/1ps
`include "bit_function_consts.vh"

module controller_bit_function_unit #(
    parameter DATA_W     = 16,
    parameter ADDR_W     = 8,
    parameter NUM_DREG   = 96,
    parameter NUM_GROUPS = 16
) (
    input  wire                         i_clk,
    input  wire                         i_reset,
    input  wire [ADDR_W-1:0]            i_addr,
    input  wire [DATA_W-1:0]            i_wr_data,
    input  wire                         i_wr_en,
    input  wire                         i_rd_en,
    input  wire [NUM_GROUPS*DATA_W-1:0] i_output_points,
    output wire [DATA_W-1:0]            o_rd_data,
    output wire                         o_refused,
    output wire                         o_done
);

    // ==========================================
    // helpers
    function [4:0] pop_count;
        input [15:0] w;
        integer k;
        begin
            pop_count = 5'h00;
            for (k = 0; k < 16; k = k + 1) begin
                pop_count = pop_count + {4'h0, w[k]};
            end
        end
    endfunction

    // lowest set bit wins if the word is not one-hot
    function [3:0] one_hot_pos;
        input [15:0] w;
        integer k;
        begin
            one_hot_pos = 4'h0;
            for (k = 15; k >= 0; k = k - 1) begin
                if (w[k]) begin
                    one_hot_pos = k[3:0];
                end
            end
        end
    endfunction

    function [15:0] group_mask;
        input [2:0] n;
        begin
            case (n)
                3'h1:    group_mask = 16'h000F;
                3'h2:    group_mask = 16'h00FF;
                3'h3:    group_mask = 16'h0FFF;
                3'h4:    group_mask = 16'hFFFF;
                default: group_mask = 16'h0000;
            endcase
        end
    endfunction

    // data registers sit in the upper half of the map, up to the last one
    function dreg_hit;
        input [7:0] a;
        begin
            dreg_hit = a[`BFU_DREG_WINDOW_BIT] &&
                       ({9'h000, a[6:0]} <= `BFU_DREG_LAST);
        end
    endfunction

    // hundreds digit not checked: the program keeps it at zero
    function transfer_ok;
        input [15:0] groups;
        input [15:0] code;
        input [15:0] dest_code;
        input [15:0] dest;
        begin
            transfer_ok = (groups >= `BFU_GROUPS_MIN) && (groups <= `BFU_GROUPS_MAX) &&
                          (code <= `BFU_GROUP_CODE_MAX) &&
                          (dest_code >= `BFU_K_THOUSAND) && (dest <= `BFU_DREG_LAST);
        end
    endfunction

    // ==========================================
    // state
    reg [DATA_W-1:0]            first_q;
    reg [DATA_W-1:0]            second_q;
    reg [DATA_W-1:0]            result_q;
    reg [DATA_W-1:0]            dreg_q [0:NUM_DREG-1];
    reg [NUM_GROUPS*DATA_W-1:0] points_meta_q;
    reg [NUM_GROUPS*DATA_W-1:0] points_sync_q;
    reg [DATA_W-1:0]            rd_data_q;
    reg                         refused_q;
    reg                         ran_q;
    reg                         done_q;
    reg [DATA_W-1:0]            first_d;
    reg [DATA_W-1:0]            second_d;
    reg [DATA_W-1:0]            result_d;
    reg [DATA_W-1:0]            rd_data_d;
    reg                         refused_d;
    reg                         ran_d;
    reg                         done_d;
    integer                     i;

    // ==========================================
    // operand decode
    wire                invoke    = i_wr_en && (i_addr == `BFU_ADDR_COMMAND);
    wire [1:0]          cmd       = i_wr_data[1:0];
    wire [15:0]         thou      = first_q / `BFU_K_THOUSAND;      // see (RULE_01)
    wire [15:0]         low_two   = first_q % `BFU_K_HUNDRED;       // see (RULE_01)
    wire [15:0]         dst       = second_q - `BFU_K_THOUSAND;     // see (RULE_05)
    wire [7:0]          grp_base  = {low_two[3:0], 4'h0};           // see (RULE_03)
    wire [DATA_W-1:0]   grp_bits  = points_sync_q[grp_base +: 16];  // see (RULE_04)
    wire                dreg_addr = dreg_hit(i_addr);
    wire [DATA_W-1:0]   inv_src   = dreg_q[first_q[6:0]];

    reg                 ex_ok;
    reg                 dreg_we;
    reg  [6:0]          dreg_idx;
    reg  [DATA_W-1:0]   dreg_val;
    reg                 second_we;
    reg  [DATA_W-1:0]   second_val;
    reg                 result_we;
    reg  [DATA_W-1:0]   result_val;

    // ==========================================
    // function execution, all in the invocation cycle
    always @* begin
        ex_ok      = 1'b0;
        dreg_we    = 1'b0;
        dreg_idx   = 7'h00;
        dreg_val   = `BFU_RESET_WORD;
        second_we  = 1'b0;
        second_val = `BFU_RESET_WORD;
        result_we  = 1'b0;
        result_val = `BFU_RESET_WORD;
        case (cmd)
            `BFU_CMD_TRANSFER: begin
                if (transfer_ok(thou, low_two, second_q, dst)) begin         // see (RULE_06)
                    ex_ok    = 1'b1;
                    dreg_we  = 1'b1;                                   // see (RULE_07)
                    dreg_idx = dst[6:0];                               // see (RULE_05)
                    dreg_val = grp_bits & group_mask(thou[2:0]);       // see (RULE_16)
                end
            end
            `BFU_CMD_DECENC: begin
                if (second_q == `BFU_SEL_DECODE) begin                 // see (RULE_12)
                    ex_ok      = 1'b1;
                    result_we  = 1'b1;
                    result_val = `BFU_ONE_BIT << first_q[3:0];         // see (RULE_08) (RULE_09)
                end else if (second_q == `BFU_SEL_ENCODE) begin        // see (RULE_12)
                    ex_ok      = 1'b1;
                    result_we  = 1'b1;
                    result_val = {12'h000, one_hot_pos(first_q)};      // see (RULE_10)
                end
            end
            `BFU_CMD_COUNT: begin
                ex_ok      = 1'b1;
                second_we  = 1'b1;
                second_val = {11'h000, pop_count(first_q)};            // see (RULE_13)
            end
            `BFU_CMD_INVERT: begin
                if (first_q <= `BFU_DREG_LAST) begin                   // see (RULE_15)
                    ex_ok    = 1'b1;
                    dreg_we  = 1'b1;
                    dreg_idx = first_q[6:0];
                    dreg_val = ~inv_src;                               // see (RULE_14)
                end
            end
            default: begin
                ex_ok = 1'b0;
            end
        endcase
    end

    // ==========================================
    // output point synchroniser
    // points come from another domain: a change reaches a transfer
    // only two edges later, the price of a clean sample
    always @(posedge i_clk) begin
        if (i_reset) begin
            points_meta_q <= {NUM_GROUPS*DATA_W{1'b0}};
            points_sync_q <= {NUM_GROUPS*DATA_W{1'b0}};
        end else begin
            points_meta_q <= i_output_points;
            points_sync_q <= points_meta_q;
        end
    end

    // ==========================================
    // next values of the operand, result and status registers
    // a command cycle never carries an operand write, so the command path wins
    always @* begin
        first_d   = first_q;
        second_d  = second_q;
        result_d  = result_q;
        refused_d = refused_q;
        ran_d     = ran_q;
        done_d    = invoke;
        if (invoke) begin
            refused_d = ~ex_ok;                                        // see (RULE_17)
            ran_d     = ex_ok;
            if (second_we) begin
                second_d = second_val;
            end
            if (result_we) begin
                result_d = result_val;
            end
        end else if (i_wr_en) begin
            if (i_addr == `BFU_ADDR_FIRST) begin
                first_d = i_wr_data;
            end
            if (i_addr == `BFU_ADDR_SECOND) begin
                second_d = i_wr_data;
            end
            if (i_addr == `BFU_ADDR_RESULT) begin
                result_d = i_wr_data;
            end
        end
    end

    // ==========================================
    // operand, result and data registers
    always @(posedge i_clk) begin
        if (i_reset) begin
            first_q   <= `BFU_RESET_WORD;
            second_q  <= `BFU_RESET_WORD;
            result_q  <= `BFU_RESET_WORD;
            refused_q <= 1'b0;
            ran_q     <= 1'b0;
            done_q    <= 1'b0;
            for (i = 0; i < NUM_DREG; i = i + 1) begin
                dreg_q[i] <= `BFU_RESET_WORD;
            end
        end else begin
            first_q   <= first_d;
            second_q  <= second_d;
            result_q  <= result_d;
            refused_q <= refused_d;
            ran_q     <= ran_d;
            done_q    <= done_d;
            if (invoke && dreg_we) begin
                // one strobe, one execution
                dreg_q[dreg_idx] <= dreg_val;                          // see (RULE_17)
            end else if (i_wr_en && dreg_addr) begin
                dreg_q[i_addr[6:0]] <= i_wr_data;
            end
        end
    end

    // ==========================================
    // read port, data valid only in the cycle after the strobe
    always @* begin
        rd_data_d = `BFU_READ_IDLE;
        if (i_rd_en) begin
            case (i_addr)
                `BFU_ADDR_FIRST:   rd_data_d = first_q;
                `BFU_ADDR_SECOND:  rd_data_d = second_q;
                `BFU_ADDR_RESULT:  rd_data_d = result_q;
                `BFU_ADDR_STATUS:  rd_data_d = {14'h0000, ran_q, refused_q};
                `BFU_ADDR_COMMAND: rd_data_d = `BFU_READ_IDLE;
                default: begin
                    // holes in the map read as zero
                    if (dreg_addr) begin
                        rd_data_d = dreg_q[i_addr[6:0]];
                    end
                end
            endcase
        end
    end

    always @(posedge i_clk) begin
        if (i_reset) begin
            rd_data_q <= `BFU_READ_IDLE;
        end else begin
            rd_data_q <= rd_data_d;
        end
    end

    assign o_rd_data = rd_data_q;
    assign o_refused = refused_q;
    assign o_done    = done_q;

endmodule

// File: verification/bit_function_unit_asserts.sv
// port checker for the bit function unit
// assumes the plain register port and a synchronous active high reset
`timescale 1ns/1ps
module bit_function_checker (
    input wire        i_clk,
    input wire        i_reset,
    input wire [7:0]  i_addr,
    input wire [15:0] i_wr_data,
    input wire        i_wr_en,
    input wire        i_rd_en,
    input wire [15:0] o_rd_data,
    input wire        o_refused,
    input wire        o_done
);
    // ==========================================
    // operand shadows
    reg  [15:0] first_q;
    reg  [15:0] sec_q;
    wire        cmd_w = i_wr_en && i_addr == 8'h03;
    // count overwrites the second operand with the set-bit count of the first
    always @(posedge i_clk) begin
        if (i_reset) begin
            first_q <= 16'h0000;
            sec_q <= 16'h0000;
        end else begin
            if (i_wr_en && i_addr == 8'h00) first_q <= i_wr_data;
            if (i_wr_en && i_addr == 8'h01) sec_q <= i_wr_data;
            if (cmd_w && i_wr_data[1:0] == 2'h2) sec_q <= 16'($countones(first_q));
        end
    end
    // ==========================================
    // port relations
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    done_after_cmd_a: assert property (cmd_w |=> o_done)
        else $error("no done after command");
    done_cause_a: assert property (o_done |-> $past(cmd_w))
        else $error("done without command");
    refused_hold_a: assert property (!cmd_w |=> $stable(o_refused))
        else $error("refused flag moved without command");
    rd_idle_a: assert property (!$past(i_rd_en) |-> o_rd_data == 16'h0000)
        else $error("read data outside read slot");
    count_taken_a: assert property (cmd_w && i_wr_data[1:0] == 2'h2 |=> !o_refused)
        else $error("count refused");
    dest_range_a: assert property (cmd_w && i_wr_data[1:0] == 2'h0
        && (sec_q < 16'h03E8 || sec_q > 16'h0447) |=> o_refused) else $error("bad dest taken");
    sel_check_a: assert property (cmd_w && i_wr_data[1:0] == 2'h1
        |=> o_refused == $past(sec_q > 16'h0001)) else $error("selector check wrong");
    invert_range_a: assert property (cmd_w && i_wr_data[1:0] == 2'h3
        |=> o_refused == $past(first_q > 16'h005F)) else $error("invert range wrong");
    status_bit_a: assert property (i_rd_en && i_addr == 8'h04
        |=> o_rd_data[0] == o_refused && o_rd_data[15:2] == 14'h0000) else $error("status wrong");
    cover property (cmd_w ##1 o_refused);
    cover property (cmd_w ##1 !o_refused);
    cover property (i_rd_en ##1 o_rd_data != 16'h0000);
endmodule
bind controller_bit_function_unit bit_function_checker chk (.i_clk(i_clk), .i_reset(i_reset),
    .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en),
    .o_rd_data(o_rd_data), .o_refused(o_refused), .o_done(o_done));

// File: verification/tb.sv
// self-checking bench for the bit function unit
// assumes the unit alone on its register port with the bench as master
`timescale 1ns/1ps
module tb;
    reg          i_clk = 1'b0;
    reg          i_reset = 1'b1;
    reg  [7:0]   i_addr = 8'h00;
    reg  [15:0]  i_wr_data = 16'h0000;
    reg          i_wr_en = 1'b0;
    reg          i_rd_en = 1'b0;
    reg  [255:0] i_output_points = 256'h0;
    wire [15:0]  o_rd_data;
    wire         o_refused;
    wire         o_done;
    reg          rd_seen = 1'b0;
    reg  [15:0]  exp_rd[$];
    reg          exp_ref[$];
    reg  [15:0]  v, g, e;
    reg          r;
    integer      num_errors = 0, num_checks = 0, i, n, c, d;
    always #2.5 i_clk = ~i_clk;
    controller_bit_function_unit uut (.i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr),
        .i_wr_data(i_wr_data), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en),
        .i_output_points(i_output_points), .o_rd_data(o_rd_data),
        .o_refused(o_refused), .o_done(o_done));
    // ==========================================
    // bus tasks
    task bus(input reg w, input reg [7:0] a, input reg [15:0] dat);
        begin
            @(posedge i_clk);
            i_wr_en <= w;
            i_rd_en <= !w;
            i_addr <= a;
            i_wr_data <= dat;
            @(posedge i_clk);
            i_wr_en <= 1'b0;
            i_rd_en <= 1'b0;
        end
    endtask
    task rd(input reg [7:0] a, input reg [15:0] x);
        begin
            exp_rd.push_back(x);
            bus(1'b0, a, 16'h0000);
        end
    endtask
    task ops(input reg [15:0] f, input reg [15:0] s);
        begin
            bus(1'b1, 8'h00, f);
            bus(1'b1, 8'h01, s);
        end
    endtask
    task cmd(input reg [1:0] k, input reg x);
        begin
            exp_ref.push_back(x);
            bus(1'b1, 8'h03, {14'h0000, k});
        end
    endtask
    // ==========================================
    // result watcher
    always @(posedge i_clk) rd_seen <= i_rd_en;
    always @(negedge i_clk) begin
        if (rd_seen === 1'b1) begin
            e = exp_rd.pop_front();
            num_checks = num_checks + 1;
            if (o_rd_data !== e) begin
                num_errors = num_errors + 1;
                $display("[FAIL] t=%0t got %h exp %h", $time, o_rd_data, e);
            end
        end
        if (o_done === 1'b1) begin
            r = exp_ref.pop_front();
            num_checks = num_checks + 1;
            if (o_refused !== r) begin
                num_errors = num_errors + 1;
                $display("[FAIL] t=%0t got %h exp %h", $time, o_refused, r);
            end
        end
    end
    task final_report;
        begin
            if (exp_rd.size() != 0 || exp_ref.size() != 0) num_errors = num_errors + 1;
            $display("checks %0d errors %0d", num_checks, num_errors);
            if (num_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
            else $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    initial begin
        #100000;
        num_errors = num_errors + 1;
        final_report;
    end
    // ==========================================
    // tests
    initial begin
        v = $urandom(44);
        repeat (4) @(posedge i_clk);
        i_reset <= 1'b0;
        for (i = 0; i < 3; i = i + 1) rd(i[7:0], 16'h0000);
        for (c = 0; c < 8; c = c + 1) i_output_points[c*32 +: 32] <= $urandom;
        @(posedge i_clk);
        for (i = 0; i < 12; i = i + 1) begin
            n = 1 + i % 4;
            c = $urandom % 16;
            d = (i == 11) ? 95 : $urandom % 96;
            g = i_output_points[c*16 +: 16] & (16'hFFFF >> (16 - 4 * n));
            ops(n * 1000 + c, 1000 + d);
            cmd(2'h0, 1'b0);
            rd(8'h80 + d[7:0], g);
        end
        for (i = 0; i < 5; i = i + 1) begin
            ops((i == 0) ? c : (i == 1) ? 5000 + c : (i == 2) ? 1016 : 1000 + c,
                (i == 3) ? 1096 : (i == 4) ? 999 : 1095);
            cmd(2'h0, 1'b1);
        end
        rd(8'hDF, g);
        rd(8'h04, 16'h0001);
        $display("transfer test done");
        for (i = 0; i < 16; i = i + 1) begin
            v = $urandom;
            ops({v[11:0], i[3:0]}, 16'h0000);
            cmd(2'h1, 1'b0);
            rd(8'h02, 16'h0001 << i);
            ops(16'h0001 << i, 16'h0001);
            cmd(2'h1, 1'b0);
            rd(8'h02, i[15:0]);
        end
        ops(16'h0001, 16'h0002);
        cmd(2'h1, 1'b1);
        $display("decode test done");
        for (i = 0; i < 6; i = i + 1) begin
            v = (i == 0) ? 16'h0000 : (i == 1) ? 16'hFFFF : $urandom;
            ops(v, 16'h0000);
            cmd(2'h2, 1'b0);
            rd(8'h01, 16'($countones(v)));
        end
        $display("count test done");
        d = $urandom % 96;
        v = $urandom;
        bus(1'b1, 8'h80 + d[7:0], v);
        ops(d, 16'h0000);
        cmd(2'h3, 1'b0);
        rd(8'h80 + d[7:0], ~v);
        cmd(2'h3, 1'b0);
        rd(8'h80 + d[7:0], v);
        rd(8'h04, 16'h0002);
        ops(16'h0060, 16'h0000);
        cmd(2'h3, 1'b1);
        rd(8'h80 + d[7:0], v);
        $display("invert test done");
        bus(1'b1, 8'h02, v);
        rd(8'h02, v);
        rd(8'h03, 16'h0000);
        rd(8'h05, 16'h0000);
        rd(8'hE0, 16'h0000);
        $display("map test done");
        repeat (2) @(posedge i_clk);
        final_report;
    end
endmodule
